//--- verilog/config_port_bridge.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bridge_defines.svh"
module config_port_bridge (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trstN,
  output logic tdo,
  output logic tdoEn,
  output logic tapAccessPending,
  input wire logic fabReq,
  input wire logic fabWrite,
  input wire logic [9:0] fabAddr,
  input wire logic [15:0] fabData,
  output logic fabDone,
  output logic [15:0] fabRdata,
  output logic portEn,
  output logic portWe,
  output logic [9:0] portAddr,
  output logic [15:0] portWdata,
  input wire logic [15:0] portRdata,
  input wire logic portReady
);
  import cfg_bridge_pkg::*;

  // tap state graph, advanced once per sampled tck rise
  function automatic tap_state_type tap_next(input tap_state_type s, input logic m);
    case (s)
      TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      default: tap_next = TAP_RESET;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage read only by second stage
  // limitation: each tck half period must span at least four clk_sys cycles
  logic [3:0] pinMeta, pinSync;
  logic tckLast;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
      tckLast <= 1'b0;
    end else begin
      pinMeta <= {trstN, tdi, tms, tck};
      pinSync <= pinMeta;
      tckLast <= pinSync[0];
    end
  end
  logic tckRise, tckFall, tmsS, tdiS, trstS;
  assign tckRise = pinSync[0] & ~tckLast;
  assign tckFall = ~pinSync[0] & tckLast;
  assign tmsS = pinSync[1];
  assign tdiS = pinSync[2];
  assign trstS = ~pinSync[3];

  ////////////////////////////////////////////////////////////////////////////
  // tap controller and scan registers, stepping on sampled tck edges
  tap_state_type tapState, next_tapState;
  logic [`IR_LEN-1:0] irShift, next_irShift, irReg, next_irReg;
  logic [`DR_LEN-1:0] drShift, next_drShift;
  logic bypassBit, next_bypassBit;
  logic next_tdo, next_tdoEn;
  logic cmdReq, next_cmdReq, cmdWrite, next_cmdWrite;
  logic [9:0] cmdAddr, next_cmdAddr;
  logic [15:0] cmdData, next_cmdData, heldData;
  logic accessSel;
  logic [3:0] cmdField;
  assign accessSel = (irReg == `IR_ACCESS); // decoded from instruction register
  assign cmdField = drShift[`CMD_MSB:`CMD_LSB];

  // one tap step per sampled tck rise; tdo only moves on the sampled fall
  always_comb begin
    next_tapState = tapState;
    next_irShift = irShift;
    next_irReg = irReg;
    next_drShift = drShift;
    next_bypassBit = bypassBit;
    next_tdo = tdo;
    next_tdoEn = tdoEn;
    next_cmdReq = 1'b0;
    next_cmdWrite = cmdWrite;
    next_cmdAddr = cmdAddr;
    next_cmdData = cmdData;
    if (trstS) begin
      next_tapState = TAP_RESET;
      next_irReg = `IR_BYPASS;
      next_tdoEn = 1'b0;
    end else if (tckRise) begin
      next_tapState = tap_next(tapState, tmsS);
      case (tapState)
        TAP_RESET: next_irReg = `IR_BYPASS;
        TAP_CAP_IR: next_irShift = {{(`IR_LEN-2){1'b0}}, 2'b01};
        TAP_SHIFT_IR: next_irShift = {tdiS, irShift[`IR_LEN-1:1]};
        TAP_UPD_IR: next_irReg = irShift; // instruction scan first
        TAP_CAP_DR: begin
          next_bypassBit = 1'b0;
          if (accessSel) begin
            next_drShift = {16'h0000, heldData};
          end
        end
        TAP_SHIFT_DR: begin
          next_bypassBit = tdiS;
          if (accessSel) begin
            next_drShift = {tdiS, drShift[`DR_LEN-1:1]}; // 32-bit path
          end
        end
        TAP_UPD_DR: begin
          if (accessSel && (cmdField == `CMD_READ || cmdField == `CMD_WRITE)) begin
            next_cmdReq = 1'b1; // other codes dropped
            next_cmdWrite = (cmdField == `CMD_WRITE);
            next_cmdAddr = drShift[`ADDR_MSB:`ADDR_LSB];
            next_cmdData = drShift[`DATA_MSB:`DATA_LSB];
          end
        end
        default: ;
      endcase
    end else if (tckFall) begin
      // tdo changes on falling tck, lsb first
      next_tdoEn = (tapState == TAP_SHIFT_DR) || (tapState == TAP_SHIFT_IR);
      if (tapState == TAP_SHIFT_IR) begin
        next_tdo = irShift[0];
      end else if (accessSel) begin
        next_tdo = drShift[0];
      end else begin
        next_tdo = bypassBit;
      end
    end
  end

  // register only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tapState <= TAP_RESET;
      irShift <= {`IR_LEN{1'b0}};
      irReg <= `IR_BYPASS;
      drShift <= {`DR_LEN{1'b0}};
      bypassBit <= 1'b0;
      tdo <= 1'b0;
      tdoEn <= 1'b0;
      cmdReq <= 1'b0;
      cmdWrite <= 1'b0;
      cmdAddr <= 10'h000;
      cmdData <= 16'h0000;
    end else begin
      tapState <= next_tapState;
      irShift <= next_irShift;
      irReg <= next_irReg;
      drShift <= next_drShift;
      bypassBit <= next_bypassBit;
      tdo <= next_tdo;
      tdoEn <= next_tdoEn;
      cmdReq <= next_cmdReq;
      cmdWrite <= next_cmdWrite;
      cmdAddr <= next_cmdAddr;
      cmdData <= next_cmdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy flag: set wins over clear so a back-to-back command is not lost
  logic tapDone, next_busy;
  always_comb begin
    next_busy = tapAccessPending;
    if (tapDone) begin
      next_busy = 1'b0;
    end
    if (cmdReq) begin
      next_busy = 1'b1;
    end
  end
  // register only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tapAccessPending <= 1'b0;
    end else begin
      tapAccessPending <= next_busy;
    end
  end

  // built-in arbitration, nothing for the user to instantiate
  config_port_arbiter arbiter (
    .clk(clk_sys),
    .rst(rst),
    .tapReq(cmdReq),
    .tapWrite(cmdWrite),
    .tapAddr(cmdAddr),
    .tapData(cmdData),
    .tapDone(tapDone),
    .heldData(heldData),
    .fabReq(fabReq),
    .fabWrite(fabWrite),
    .fabAddr(fabAddr),
    .fabData(fabData),
    .fabDone(fabDone),
    .fabRdata(fabRdata),
    .portEn(portEn),
    .portWe(portWe),
    .portAddr(portAddr),
    .portWdata(portWdata),
    .portRdata(portRdata),
    .portReady(portReady)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // arbitration cycles of a tap transaction; the port's own wait states are
  // its business, so they are not counted against the six-cycle budget
  logic [3:0] busyCount;
  always_ff @(posedge clk_sys) begin
    if (rst || !tapAccessPending) begin
      busyCount <= 4'h0;
    end else if (busyCount != 4'hF && !(portEn && !portReady)) begin
      busyCount <= busyCount + 4'h1;
    end
  end

  write_done_six_a: assert property (@(posedge clk_sys) disable iff (rst)
    busyCount <= 4'(`WRITE_LIMIT)) else $error("tap write took over six cycles");
  capture_upper_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tckRise && tapState == TAP_CAP_DR && accessSel && !trstS)
    |=> drShift[31:16] == 16'h0000) else $error("upper capture bits not zero");
  capture_held_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tckRise && tapState == TAP_CAP_DR && accessSel && !trstS)
    |=> drShift[15:0] == $past(heldData)) else $error("capture missed held data");
  update_busy_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmdReq |=> tapAccessPending) else $error("busy not raised at update");
  bad_cmd_nop_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tckRise && tapState == TAP_UPD_DR && !trstS && cmdField != `CMD_READ
     && cmdField != `CMD_WRITE) |=> !cmdReq) else $error("undefined command issued");
  access_decode_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmdReq |-> $past(irReg) == `IR_ACCESS) else $error("command without access instr");
  shift_lsb_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tckFall && tapState == TAP_SHIFT_DR && accessSel && !trstS)
    |=> tdo == $past(drShift[0]) && tdoEn) else $error("tdo not lsb of shifter");
  done_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tapDone && !cmdReq) |=> !tapAccessPending) else $error("busy stuck after done");

  // scan framing and command decode at the sampled tck edges, then busy, held data and command stability every system clock
  // a broken field slice or shift direction shows up on the first write scan
  update_fields_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tckRise && tapState == TAP_UPD_DR && accessSel && !trstS && cmdField == `CMD_WRITE)
    |=> cmdReq && cmdWrite && cmdAddr == $past(drShift[`ADDR_MSB:`ADDR_LSB])
    && cmdData == $past(drShift[`DATA_MSB:`DATA_LSB])) else $error("write fields misplaced");
  read_kind_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tckRise && tapState == TAP_UPD_DR && accessSel && !trstS && cmdField == `CMD_READ)
    |=> cmdReq && !cmdWrite) else $error("read command not issued as read");
  tdo_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tckFall && tapState != TAP_SHIFT_DR && tapState != TAP_SHIFT_IR && !trstS)
    |=> !tdoEn) else $error("tdo driven outside shift");
  shift_in_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tckRise && tapState == TAP_SHIFT_DR && accessSel && !trstS)
    |=> drShift[`DR_LEN-1] == $past(tdiS)) else $error("tdi not entering msb");
  ir_capture_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tckRise && tapState == TAP_CAP_IR && !trstS)
    |=> irShift[1:0] == 2'b01) else $error("instruction capture pattern wrong");
  busy_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!tapAccessPending && !cmdReq) |=> !tapAccessPending)
    else $error("busy raised without update");
  held_stable_a: assert property (@(posedge clk_sys) disable iff (rst)
    !tapDone |=> $stable(heldData))
    else $error("held data moved without completion");
  cmd_stable_a: assert property (@(posedge clk_sys) disable iff (rst)
    !cmdReq |-> $stable(cmdWrite) && $stable(cmdAddr) && $stable(cmdData))
    else $error("command changed between updates");
endmodule
`default_nettype wire

//--- verilog/cfg_bridge_defines.svh
`ifndef CFG_BRIDGE_DEFINES_SVH
`define CFG_BRIDGE_DEFINES_SVH
`define IR_LEN 10
`define IR_ACCESS 10'h3F7
`define IR_BYPASS 10'h3FF
`define DR_LEN 32
`define DATA_LSB 0
`define DATA_MSB 15
`define ADDR_LSB 16
`define ADDR_MSB 25
`define CMD_LSB 26
`define CMD_MSB 29
`define CMD_NOP 4'h0
`define CMD_READ 4'h1
`define CMD_WRITE 4'h2
`define HELD_RESET 16'h0000
`define WRITE_LIMIT 6
`endif

//--- verilog/cfg_bridge_pkg.sv
package cfg_bridge_pkg;
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SHIFT_DR = 4'h4, TAP_EXIT1_DR = 4'h5, TAP_PAUSE_DR = 4'h6, TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SHIFT_IR = 4'hB,
    TAP_EXIT1_IR = 4'hC, TAP_PAUSE_IR = 4'hD, TAP_EXIT2_IR = 4'hE, TAP_UPD_IR = 4'hF
  } tap_state_type;
  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00, ARB_FABRIC = 2'b01, ARB_TAP = 2'b10
  } arb_state_type;
endpackage

//--- verilog/config_port_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bridge_defines.svh"
// grants the port one transaction at a time; tap requests are queued behind fabric ones
module config_port_arbiter (
  input wire logic clk,
  input wire logic rst,
  input wire logic tapReq,
  input wire logic tapWrite,
  input wire logic [9:0] tapAddr,
  input wire logic [15:0] tapData,
  output logic tapDone,
  output logic [15:0] heldData,
  input wire logic fabReq,
  input wire logic fabWrite,
  input wire logic [9:0] fabAddr,
  input wire logic [15:0] fabData,
  output logic fabDone,
  output logic [15:0] fabRdata,
  output logic portEn,
  output logic portWe,
  output logic [9:0] portAddr,
  output logic [15:0] portWdata,
  input wire logic [15:0] portRdata,
  input wire logic portReady
);
  import cfg_bridge_pkg::*;
  arb_state_type state, next_state;
  logic tapPend, next_tapPend, fabPend, next_fabPend;
  logic pendWrite, next_pendWrite, fWrite, next_fWrite;
  logic [9:0] pendAddr, next_pendAddr, fAddr, next_fAddr;
  logic [15:0] pendData, next_pendData, fData, next_fData;
  logic [15:0] next_heldData, next_fabRdata;

  // queue both sides, launch one transaction, never preempt
  always_comb begin
    next_state = state;
    next_tapPend = tapPend | tapReq;
    next_fabPend = fabPend | fabReq;
    next_pendWrite = pendWrite;
    next_pendAddr = pendAddr;
    next_pendData = pendData;
    next_fWrite = fabReq ? fabWrite : fWrite;
    next_fAddr = fabReq ? fabAddr : fAddr;
    next_fData = fabReq ? fabData : fData;
    next_heldData = heldData;
    next_fabRdata = fabRdata;
    portEn = 1'b0;
    portWe = 1'b0;
    portAddr = pendAddr;
    portWdata = pendData;
    tapDone = 1'b0;
    fabDone = 1'b0;
    case (state)
      ARB_IDLE: begin
        if (fabPend) begin
          next_state = ARB_FABRIC; // fabric already waiting goes first
        end else if (tapPend) begin
          // latch at launch so a later update cannot disturb a running transfer
          next_state = ARB_TAP;
          next_tapPend = 1'b0;
          next_pendWrite = tapWrite;
          next_pendAddr = tapAddr;
          next_pendData = tapData;
        end
      end
      ARB_FABRIC: begin
        portEn = 1'b1;
        portWe = fWrite;
        portAddr = fAddr;
        portWdata = fData;
        if (portReady) begin
          fabDone = 1'b1;
          next_fabPend = fabReq;
          next_fabRdata = portRdata;
          next_state = ARB_IDLE;
        end
      end
      ARB_TAP: begin
        portEn = 1'b1;
        portWe = pendWrite;
        if (portReady) begin
          tapDone = 1'b1;
          next_heldData = pendWrite ? pendData : portRdata; // written or read word held
          next_state = ARB_IDLE;
        end
      end
      default: next_state = ARB_IDLE;
    endcase
  end

  // register only
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ARB_IDLE;
      tapPend <= 1'b0;
      fabPend <= 1'b0;
      pendWrite <= 1'b0;
      pendAddr <= 10'h000;
      pendData <= 16'h0000;
      fWrite <= 1'b0;
      fAddr <= 10'h000;
      fData <= 16'h0000;
      heldData <= `HELD_RESET;
      fabRdata <= 16'h0000;
    end else begin
      state <= next_state;
      tapPend <= next_tapPend;
      fabPend <= next_fabPend;
      pendWrite <= next_pendWrite;
      pendAddr <= next_pendAddr;
      pendData <= next_pendData;
      fWrite <= next_fWrite;
      fAddr <= next_fAddr;
      fData <= next_fData;
      heldData <= next_heldData;
      fabRdata <= next_fabRdata;
    end
  end

  grant_held_a: assert property (@(posedge clk) disable iff (rst)
    (portEn && !portReady) |=> portEn && $stable(portWe) && $stable(portAddr)
    && $stable(portWdata)) else $error("port request changed before ready");
endmodule
`default_nettype wire

//--- tb/config_port_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side of the config port: a register file that answers after a chosen delay
module config_port_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic portEn,
  input wire logic portWe,
  input wire logic [9:0] portAddr,
  input wire logic [15:0] portWdata,
  output logic [15:0] portRdata,
  output logic portReady,
  input wire logic [7:0] delay
);
  logic [15:0] mem [0:1023];
  logic [7:0] waitCnt;
  initial for (int i = 0; i < 1024; i++) mem[i] = 16'hA5C3 ^ 16'(i);
  // read data toggles when not answering, so a late sample never looks valid;
  // plain always because the initial block also fills the array
  always @(posedge clk) begin
    if (rst) begin
      portReady <= 1'b0;
      waitCnt <= 8'h00;
      portRdata <= 16'h0000;
    end else if (portEn && !portReady && waitCnt >= delay) begin
      portReady <= 1'b1;
      portRdata <= mem[portAddr];
      if (portWe) mem[portAddr] <= portWdata;
    end else begin
      portReady <= 1'b0;
      portRdata <= ~portRdata;
      waitCnt <= (portEn && !portReady) ? waitCnt + 8'h01 : 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- tb/jtag_config_port_bridge_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bridge_defines.svh"
module jtag_config_port_bridge_bench;
  logic clk_sys = 0, rst = 1, tck = 0, tms = 1, tdi = 0, trstN = 0;
  logic tdo, tdoEn, tapAccessPending, fabDone, portEn, portWe, portReady;
  logic fabReq = 0, fabWrite = 0;
  logic [9:0] fabAddr = 0, portAddr;
  logic [15:0] fabData = 0, fabRdata, portWdata, portRdata;
  logic [7:0] delay = 0;
  int miscompares = 0, n_checks = 0, seed = 77762;
  logic [31:0] dout;
  logic [15:0] held, d, v, r;
  logic [9:0] a;
  always #50 clk_sys = ~clk_sys;
  config_port_bridge config_port_bridge_i (.clk_sys(clk_sys), .rst(rst), .tck(tck),
    .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo), .tdoEn(tdoEn),
    .tapAccessPending(tapAccessPending), .fabReq(fabReq), .fabWrite(fabWrite),
    .fabAddr(fabAddr), .fabData(fabData), .fabDone(fabDone), .fabRdata(fabRdata),
    .portEn(portEn), .portWe(portWe), .portAddr(portAddr), .portWdata(portWdata),
    .portRdata(portRdata), .portReady(portReady));
  config_port_model config_port_model_i (.clk(clk_sys), .rst(rst), .portEn(portEn),
    .portWe(portWe), .portAddr(portAddr), .portWdata(portWdata),
    .portRdata(portRdata), .portReady(portReady), .delay(delay));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] cmd_word(logic [3:0] c, logic [9:0] ad, logic [15:0] da);
    return {2'b00, c, ad, da};
  endfunction
  function automatic logic [31:0] cap_word(logic [15:0] da);
    return {16'h0000, da};
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one test clock of 800 ns; tdo is sampled late in the high phase because it
  // trails the sampled falling edge by a few system clocks
  task automatic step(logic m, logic i, output logic o);
    tms = m;
    tdi = i;
    repeat (4) @(posedge clk_sys);
    #1 tck = 1;
    repeat (4) @(posedge clk_sys);
    #1 o = tdo;
    tck = 0;
  endtask
  task automatic idle(int n);
    logic o;
    for (int k = 0; k < n; k++) step(0, 0, o);
  endtask
  task automatic load_ir(logic [9:0] code);
    logic o;
    step(1, 0, o);
    step(1, 0, o);
    step(0, 0, o);
    step(0, 0, o);
    for (int k = 0; k < 10; k++) step(k == 9, code[k], o);
    step(1, 0, o);
    step(0, 0, o);
  endtask
  // command goes in lsb first while the captured word comes out
  task automatic scan_dr(logic [31:0] din, output logic [31:0] q);
    logic o;
    step(1, 0, o);
    step(0, 0, o);
    step(0, 0, o);
    for (int k = 0; k < 32; k++) begin
      step(k == 31, din[k], q[k]);
      if (k == 0) check("output enable", 32'(tdoEn), 32'h1);
    end
    step(1, 0, o);
    step(0, 0, o);
    check("output enable", 32'(tdoEn), 32'h0);
  endtask
  task automatic fab_op(logic we, logic [9:0] ad, logic [15:0] da, output logic [15:0] rd);
    int n;
    @(posedge clk_sys);
    #1 {fabReq, fabWrite, fabAddr, fabData} = {1'b1, we, ad, da};
    @(posedge clk_sys);
    #1 fabReq = 0;
    for (n = 0; n < 400 && fabDone !== 1'b1; n++) @(negedge clk_sys);
    if (n == 400) begin
      miscompares++;
      complete_run();
    end else begin
      @(negedge clk_sys);
      rd = fabRdata;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rst = 0;
    trstN = 1;
    repeat (5) @(posedge clk_sys);
    for (int k = 0; k < 6; k++) step(1, 0, dout[0]);
    step(0, 0, dout[0]);
    load_ir(`IR_ACCESS);
    // writes with random data, each read back through the next capture
    for (int t = 0; t < 4; t++) begin
      a = 10'($random(seed));
      d = 16'($random(seed));
      scan_dr(cmd_word(`CMD_WRITE, a, d), dout);
      idle(10);
      check("port word", config_port_model_i.mem[a], d);
      scan_dr(cmd_word(`CMD_NOP, a, ~d), dout);
      check("capture", dout, cap_word(d));
      held = d;
    end
    $display("write test done");
    // pipelined reads, each scan returns the previous read
    a = 10'h3FF;
    scan_dr(cmd_word(`CMD_READ, a, 16'h0000), dout);
    idle(10);
    for (int t = 0; t < 5; t++) begin
      v = config_port_model_i.mem[a];
      a = (t == 0) ? 10'h000 : 10'($random(seed));
      scan_dr(cmd_word(`CMD_READ, a, 16'($random(seed))), dout);
      check("read", dout, cap_word(v));
      idle(10);
    end
    held = config_port_model_i.mem[a];
    $display("read test done");
    // undefined codes touch nothing
    for (int c = 3; c < 16; c++) begin
      v = config_port_model_i.mem[10'h055];
      scan_dr(cmd_word(4'(c), 10'h055, ~v), dout);
      check("capture", dout, cap_word(held));
      idle(10);
      check("port word", config_port_model_i.mem[10'h055], v);
    end
    $display("code test done");
    // slow port: early capture is stale, and a fabric write waits its turn
    delay = 8'd40;
    v = config_port_model_i.mem[10'h123];
    d = ~v;
    scan_dr(cmd_word(`CMD_READ, 10'h123, 16'h0000), dout);
    check("pending", 32'(tapAccessPending), 32'h1);
    fork
      scan_dr(cmd_word(`CMD_NOP, 10'h000, 16'h0000), dout);
      fab_op(1'b1, 10'h123, d, r);
    join
    check("stale capture", dout, cap_word(held));
    held = v;
    idle(30);
    check("pending", 32'(tapAccessPending), 32'h0);
    scan_dr(cmd_word(`CMD_NOP, 10'h000, 16'h0000), dout);
    check("capture", dout, cap_word(held));
    fab_op(1'b0, 10'h123, 16'h0000, r);
    check("fabric read", r, d);
    $display("arbitration test done");
    complete_run();
  end
endmodule
`default_nettype wire
